//--- frame_sync_config_freeze_bench.sv
`timescale 1ns/100ps
`include "fscf_consts.svh"
module frame_sync_config_freeze_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        fs = 1'b0;
    logic        ls = 1'b0;
    logic        pv = 1'b0;
    logic [9:0]  pd = 10'h000;
    logic [8:0]  addr;
    logic [15:0] wdata, rdata, rv, sy, v, xl, dm, mt, fp, ex;
    logic        wr, rd, ss, bn, blk, trn, opv;
    logic [7:0]  bl, ag, we;
    logic [4:0]  mg;
    logic [9:0]  opd;
    logic [15:0] e_xl = 0, e_bl = 1, e_dm = 0, e_mt = 0, e_fp = 0, e_ex = 0;
    logic [15:0] e_gn = 0, e_wn = 1, e_tr = 0, s_gn, s_md = 0, s_we;
    logic [15:0] s_xl, s_bl, s_dm, s_mt, s_fp, s_ex;
    logic [15:0] off [8];
    int          mismatches = 0;
    int          checked = 0;
    int          seed = 39432;
    always #10 clk = ~clk;
    fscf_top u_fscf_top (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_FRAME_START(fs),
        .I_LINE_START(ls), .I_PIX_VALID(pv), .I_PIX_DATA(pd), .O_RDATA(rdata),
        .O_ROLLING_LINE_LENGTH(xl), .O_BLACK_LINES(bl), .O_DUMMY_LINES(dm),
        .O_MULT_TIMER(mt), .O_FRAME_PERIOD(fp), .O_EXPOSURE(ex),
        .O_MUX_GAINSW(mg), .O_AFE_GAIN(ag), .O_WINDOW_ENABLE_BITS(we),
        .O_SUBSAMPLING(ss), .O_BINNING(bn), .O_BLACK_LINE(blk),
        .O_TRAINING(trn), .O_PIX_VALID(opv), .O_PIX_DATA(opd));
    fscf_ctrl_model u_fscf_ctrl_model (.i_clk(clk), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    task automatic chk(input string n, input logic [15:0] x, g);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    function automatic logic [15:0] pick(input logic b,
                                         input logic [15:0] a, s);
        return b ? s : a;
    endfunction
    function automatic logic [15:0] clip(input logic [15:0] p, o);
        return (p + 16'h0005 < o) ? 16'h0000 : p + 16'h0005 - o;
    endfunction
    task automatic upd(input logic [15:0] y);
        e_tr = {15'h0, s_md[1] & y[8] & y[5] & (s_we[7:0] != e_wn[7:0])};
        e_xl = pick(y[0] & s_md[1], e_xl, s_xl);
        e_bl = pick(y[1], e_bl, s_bl);
        e_dm = pick(y[2], e_dm, s_dm);
        e_mt = pick(y[3], e_mt, s_mt);
        e_fp = pick(y[3], e_fp, s_fp);
        e_ex = pick(y[3], e_ex, s_ex);
        e_gn = pick(y[4], e_gn, s_gn & 16'h1fff);
        e_wn = pick(y[5], e_wn, {7'h00, s_md[8:7], s_we[7:0]});
    endtask
    task automatic cmp_all();
        chk("xlen", e_xl, xl);
        chk("black", e_bl, {8'h00, bl});
        chk("dummy", e_dm, dm);
        chk("mult", e_mt, mt);
        chk("period", e_fp, fp);
        chk("expo", e_ex, ex);
        chk("gain", e_gn, {3'h0, ag, mg});
        chk("win", e_wn, {7'h00, bn, ss, we});
        chk("train", e_tr, {15'h0, trn});
    endtask
    task automatic frame();
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        #1;
    endtask
    task automatic line();
        @(posedge clk);
        ls <= 1'b1;
        @(posedge clk);
        ls <= 1'b0;
    endtask
    task automatic pix(input logic [15:0] d);
        @(posedge clk);
        pv <= 1'b1;
        pd <= d[9:0];
        @(posedge clk);
        pv <= 1'b0;
        #1;
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        $display("watchdog expired");
        mismatches++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        u_fscf_ctrl_model.rd(`FSCF_A_SYNC, rv);
        chk("sync", 16'h003f, rv);
        cmp_all();
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            sy = (i == 0) ? 16'h0000 : (i == 1) ? 16'h003f : $random(seed);
            sy = sy & 16'h003f;
            s_xl = $random(seed);
            s_bl = 16'h0001 + 16'($unsigned($random(seed)) % 255);
            s_dm = $random(seed);
            s_mt = $random(seed);
            s_fp = $random(seed);
            s_ex = $random(seed);
            s_gn = $random(seed);
            s_md = $random(seed) & 16'h0180;
            s_we = $random(seed) & 16'h00ff;
            u_fscf_ctrl_model.wr(`FSCF_A_SYNC, 16'h0000);
            u_fscf_ctrl_model.wr(`FSCF_A_XLEN, s_xl);
            u_fscf_ctrl_model.wr(`FSCF_A_BLACK, s_bl);
            u_fscf_ctrl_model.wr(`FSCF_A_DUMMY, s_dm);
            u_fscf_ctrl_model.wr(`FSCF_A_MULT, s_mt);
            u_fscf_ctrl_model.wr(`FSCF_A_FRAME, s_fp);
            u_fscf_ctrl_model.wr(`FSCF_A_EXPO, s_ex);
            u_fscf_ctrl_model.wr(`FSCF_A_GAIN, s_gn);
            u_fscf_ctrl_model.wr(`FSCF_A_MODE, s_md);
            u_fscf_ctrl_model.wr(`FSCF_A_WIN_EN, s_we);
            u_fscf_ctrl_model.wr(`FSCF_A_SYNC, sy);
            frame();
            upd(sy);
            cmp_all();
        end
        $display("freeze test done");
        for (int a = 0; a < 24; a += 23) begin
            v = $random(seed);
            u_fscf_ctrl_model.wr(9'(256 + a), v);
            u_fscf_ctrl_model.rd(9'(256 + a), rv);
            chk("geom", v, rv);
        end
        u_fscf_ctrl_model.rd(9'h1ff, rv);
        chk("unmapped", 16'h0000, rv);
        $display("window test done");
        s_md = 16'h0002;
        s_xl = 16'h0123;
        s_we = (e_wn[7:0] == 8'h04) ? 16'h0008 : 16'h0004;
        u_fscf_ctrl_model.wr(`FSCF_A_MODE, s_md);
        u_fscf_ctrl_model.wr(`FSCF_A_XLEN, s_xl);
        u_fscf_ctrl_model.wr(`FSCF_A_WIN_EN, s_we);
        for (int k = 0; k < 3; k++) begin
            sy = (k == 2) ? 16'h013e : 16'h013f;
            if (k == 2) s_xl = 16'h0456;
            u_fscf_ctrl_model.wr(`FSCF_A_XLEN, s_xl);
            u_fscf_ctrl_model.wr(`FSCF_A_SYNC, sy);
            frame();
            upd(sy);
            cmp_all();
            pix(16'h0010);
            if (k == 0) chk("muted", 16'h0000, {15'h0, opv});
            if (k == 1) chk("unmuted", 16'h0001, {15'h0, opv});
        end
        u_fscf_ctrl_model.rd(`FSCF_A_STATUS, rv);
        chk("status", {e_wn[7:0], 6'h00, e_tr[0], s_md[1]}, rv);
        $display("rolling test done");
        s_md = 16'h0000;
        u_fscf_ctrl_model.wr(`FSCF_A_MODE, s_md);
        u_fscf_ctrl_model.wr(`FSCF_A_SYNC, 16'h003f);
        u_fscf_ctrl_model.wr(`FSCF_A_BLACK, 16'h0102);
        u_fscf_ctrl_model.wr(`FSCF_A_TARGET, 16'h0005);
        frame();
        // first black line gated; line two leaves columns 4-7 untouched
        for (int l = 0; l < 3; l++) begin
            line();
            for (int c = 0; c < 8; c++) begin
                v = $random(seed) & 16'h003f;
                if (l == 0) begin
                    off[c] = $random(seed) & 16'h001f;
                    if (c >= 4) off[c] = 16'h0000;
                    if (c == 0) off[c] = 16'h001f;
                end
                if (l == 1) v = off[c];
                if (l == 2 && c == 0) v = 16'h0000;
                if (l == 1 && c >= 4) continue;
                pix(v);
                if (l < 2) chk("blkline", 16'h0001, {15'h0, blk});
                else chk("pixel", clip(v, off[c]), {6'h00, opd});
                if (l == 2) chk("imgline", 16'h0000, {15'h0, blk});
            end
        end
        $display("black test done");
        results();
    end
endmodule // frame_sync_config_freeze_bench

//--- fscf_consts.svh
`ifndef FSCF_CONSTS_SVH
`define FSCF_CONSTS_SVH

// register addresses (word index on the register port)
`define FSCF_A_MODE       9'h0c0
`define FSCF_A_XLEN       9'h0c1
`define FSCF_A_WIN_EN     9'h0c3
`define FSCF_A_BLACK      9'h0c5
`define FSCF_A_DUMMY      9'h0c6
`define FSCF_A_MULT       9'h0c7
`define FSCF_A_FRAME      9'h0c8
`define FSCF_A_EXPO       9'h0c9
`define FSCF_A_GAIN       9'h0cc
`define FSCF_A_SYNC       9'h0ce
`define FSCF_A_TARGET     9'h0cf
`define FSCF_A_STATUS     9'h0d0
`define FSCF_A_WIN_FIRST  9'h100
`define FSCF_A_WIN_LAST   9'h117

// field positions
`define FSCF_B_ROLLING    1
`define FSCF_B_SUBSAMPLE  7
`define FSCF_B_BINNING    8
`define FSCF_B_GATE_FIRST 8
`define FSCF_B_S_XLEN     0
`define FSCF_B_S_BLACK    1
`define FSCF_B_S_DUMMY    2
`define FSCF_B_S_EXPO     3
`define FSCF_B_S_GAIN     4
`define FSCF_B_S_WIN      5
`define FSCF_B_BLANK_SW   8

// reset values
`define FSCF_R_SYNC       16'h003f
`define FSCF_R_BLACK      16'h0001
`define FSCF_R_WIN_EN     8'h01
`define FSCF_R_WORD       16'h0000

`endif

//--- fscf_ctrl_model.sv
`timescale 1ns/100ps
module fscf_ctrl_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic [8:0]       o_addr,
    output logic [15:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial begin
        o_addr = 9'h000;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // data inverted once released, so stale values never look valid
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule // fscf_ctrl_model

//--- fscf_pkg.sv
package fscf_pkg;
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_BLACK,
        LK_IMAGE
    } fscf_line_kind_t;
    typedef logic [15:0] fscf_word_t;
endpackage

//--- fscf_top.sv
// Function
// - readout parameters change only at frame start
// - cleared group bit keeps old active values
// - set group bit loads latest written values, line length only in rolling shutter
// - group sync bits live at address 206
// - line-length bit gates rolling line length
// - dark-row bit gates black-line count
// - filler-row bit gates dummy-line count
// - exposure bit gates multiplier, period, exposure
// - gain bit gates gain switch, front-end gain
// - window bit gates enables, subsample, binning
// - window geometry is never frozen
// - eight windows at addresses 256 to 279
// - each window enabled by bit of 195
// - one write to 195 switches window sets
// - 206 bit 8 blanks frame after switch in rolling shutter only
// - blank frame sends training for whole frame
// - black lines at each frame start, recalibrate
// - programmable black target, clip below zero
// - black level per each of 8 columns
`timescale 1ns/100ps
`include "fscf_consts.svh"
module fscf_top #(
    parameter int PIX_W  = 10,
    parameter int KERNEL = 8,
    parameter int NWIN   = 8
) (
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic [8:0]        I_ADDR,
    input  wire logic [15:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    input  wire logic              I_FRAME_START,
    input  wire logic              I_LINE_START,
    input  wire logic              I_PIX_VALID,
    input  wire logic [PIX_W-1:0]  I_PIX_DATA,
    output logic [15:0]            O_RDATA,
    output logic [15:0]            O_ROLLING_LINE_LENGTH,
    output logic [7:0]             O_BLACK_LINES,
    output logic [15:0]            O_DUMMY_LINES,
    output logic [15:0]            O_MULT_TIMER,
    output logic [15:0]            O_FRAME_PERIOD,
    output logic [15:0]            O_EXPOSURE,
    output logic [4:0]             O_MUX_GAINSW,
    output logic [7:0]             O_AFE_GAIN,
    output logic [NWIN-1:0]        O_WINDOW_ENABLE_BITS,
    output logic                   O_SUBSAMPLING,
    output logic                   O_BINNING,
    output logic                   O_BLACK_LINE,
    output logic                   O_TRAINING,
    output logic                   O_PIX_VALID,
    output logic [PIX_W-1:0]       O_PIX_DATA
);
    if (PIX_W < 4 || PIX_W > 14 || KERNEL != 8 || NWIN != 8) begin : g_chk
        $error("fscf_top: unsupported parameter values");
    end

    localparam int CW = $clog2(KERNEL);
    localparam int SW = PIX_W + 2;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] k);
        hit = (a == k);
    endfunction

    // target plus pixel minus offset, clipped into the output range
    function automatic logic [PIX_W-1:0] clip(input logic [SW-1:0] v);
        if (v[SW-1]) begin
            clip = '0;
        end else if (|v[SW-2:PIX_W]) begin
            clip = '1;
        end else begin
            clip = v[PIX_W-1:0];
        end
    endfunction

    // ---- register port decode
    wire        wr_mode   = I_WR && hit(I_ADDR, `FSCF_A_MODE);
    wire        wr_xlen   = I_WR && hit(I_ADDR, `FSCF_A_XLEN);
    wire        wr_win_en = I_WR && hit(I_ADDR, `FSCF_A_WIN_EN);
    wire        wr_black  = I_WR && hit(I_ADDR, `FSCF_A_BLACK);
    wire        wr_dummy  = I_WR && hit(I_ADDR, `FSCF_A_DUMMY);
    wire        wr_mult   = I_WR && hit(I_ADDR, `FSCF_A_MULT);
    wire        wr_frame  = I_WR && hit(I_ADDR, `FSCF_A_FRAME);
    wire        wr_expo   = I_WR && hit(I_ADDR, `FSCF_A_EXPO);
    wire        wr_gain   = I_WR && hit(I_ADDR, `FSCF_A_GAIN);
    wire        wr_sync   = I_WR && hit(I_ADDR, `FSCF_A_SYNC);
    wire        wr_target = I_WR && hit(I_ADDR, `FSCF_A_TARGET);
    wire        win_range = (I_ADDR >= `FSCF_A_WIN_FIRST) &&
                            (I_ADDR <= `FSCF_A_WIN_LAST);
    wire [8:0]  win_off   = I_ADDR - `FSCF_A_WIN_FIRST;

    // shadow set, written by software at any time
    logic [15:0]      mode_q, xlen_q, dummy_q, mult_q, frame_q, expo_q;
    logic [15:0]      gain_q, sync_q;
    logic [8:0]       black_q;
    logic [NWIN-1:0]  win_en_q;
    logic [PIX_W-1:0] target_q;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            mode_q   <= `FSCF_R_WORD;
            xlen_q   <= `FSCF_R_WORD;
            dummy_q  <= `FSCF_R_WORD;
            mult_q   <= `FSCF_R_WORD;
            frame_q  <= `FSCF_R_WORD;
            expo_q   <= `FSCF_R_WORD;
            gain_q   <= `FSCF_R_WORD;
            sync_q   <= `FSCF_R_SYNC;
            black_q  <= 9'(`FSCF_R_BLACK);
            win_en_q <= `FSCF_R_WIN_EN;
            target_q <= '0;
        end else begin
            if (wr_mode) begin
                mode_q <= I_WDATA;
            end
            if (wr_xlen) begin
                xlen_q <= I_WDATA;
            end
            if (wr_dummy) begin
                dummy_q <= I_WDATA;
            end
            if (wr_mult) begin
                mult_q <= I_WDATA;
            end
            if (wr_frame) begin
                frame_q <= I_WDATA;
            end
            if (wr_expo) begin
                expo_q <= I_WDATA;
            end
            if (wr_gain) begin
                gain_q <= I_WDATA;
            end
            if (wr_sync) begin
                sync_q <= I_WDATA;
            end
            if (wr_black) begin
                black_q <= I_WDATA[8:0];
            end
            if (wr_win_en) begin
                win_en_q <= I_WDATA[NWIN-1:0];
            end
            if (wr_target) begin
                target_q <= I_WDATA[PIX_W-1:0];
            end
        end
    end

    // ---- per-group transfer strobes, only at a frame boundary
    wire rolling   = mode_q[`FSCF_B_ROLLING];
    wire ld_xlen   = I_FRAME_START && sync_q[`FSCF_B_S_XLEN];
    wire ld_black  = I_FRAME_START && sync_q[`FSCF_B_S_BLACK];
    wire ld_dummy  = I_FRAME_START && sync_q[`FSCF_B_S_DUMMY];
    wire ld_expo   = I_FRAME_START && sync_q[`FSCF_B_S_EXPO];
    wire ld_gain   = I_FRAME_START && sync_q[`FSCF_B_S_GAIN];
    wire ld_win    = I_FRAME_START && sync_q[`FSCF_B_S_WIN];
    wire win_swap  = ld_win && (win_en_q != O_WINDOW_ENABLE_BITS);
    wire blank_now = win_swap && rolling &&
                     sync_q[`FSCF_B_BLANK_SW];
    // line length only matters in rolling shutter; global mode skips it
    wire ld_xlen_r = ld_xlen && rolling;

    // black-line count valid for the frame that is starting now
    wire [7:0] black_now = ld_black ? black_q[7:0] : O_BLACK_LINES;
    logic      gate_first_q;

    // active set: cleared bit holds it, set bit copies shadow (line length only in rolling shutter)
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            O_ROLLING_LINE_LENGTH <= `FSCF_R_WORD;
            O_DUMMY_LINES         <= `FSCF_R_WORD;
            O_MULT_TIMER          <= `FSCF_R_WORD;
            O_FRAME_PERIOD        <= `FSCF_R_WORD;
            O_EXPOSURE            <= `FSCF_R_WORD;
            O_BLACK_LINES         <= 8'(`FSCF_R_BLACK);
            gate_first_q          <= 1'b0;
            O_MUX_GAINSW          <= '0;
            O_AFE_GAIN            <= '0;
            O_WINDOW_ENABLE_BITS  <= `FSCF_R_WIN_EN;
            O_SUBSAMPLING         <= 1'b0;
            O_BINNING             <= 1'b0;
        end else begin
            if (ld_xlen_r) begin
                O_ROLLING_LINE_LENGTH <= xlen_q;
            end
            if (ld_black) begin
                O_BLACK_LINES <= black_q[7:0];
                gate_first_q  <= black_q[`FSCF_B_GATE_FIRST];
            end
            if (ld_dummy) begin
                O_DUMMY_LINES <= dummy_q;
            end
            if (ld_expo) begin
                O_MULT_TIMER   <= mult_q;
                O_FRAME_PERIOD <= frame_q;
                O_EXPOSURE     <= expo_q;
            end
            if (ld_gain) begin
                O_MUX_GAINSW <= gain_q[4:0];
                O_AFE_GAIN   <= gain_q[12:5];
            end
            if (ld_win) begin
                O_WINDOW_ENABLE_BITS <= win_en_q;
                O_SUBSAMPLING        <= mode_q[`FSCF_B_SUBSAMPLE];
                O_BINNING            <= mode_q[`FSCF_B_BINNING];
            end
        end
    end

    // window geometry: written straight through, no shadow
    fscf_pkg::fscf_word_t geom_rdata;
    // keep the read index inside the array for unmapped addresses
    wire [4:0]            geom_addr = win_range ? win_off[4:0] : 5'h00;

    fscf_win_mem #(
        .DEPTH (3 * NWIN),
        .AW    (5)
    ) u_geom (
        .I_SYS_CLK (I_SYS_CLK),
        .i_we      (I_WR && win_range),
        .i_addr    (geom_addr),
        .i_wdata   (I_WDATA),
        .o_rdata   (geom_rdata)
    );

    // ---- training frame after a rolling-shutter window switch
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            O_TRAINING <= 1'b0;
        end else if (I_FRAME_START) begin
            O_TRAINING <= blank_now;
        end
    end

    // line classification at the frame head
    fscf_pkg::fscf_line_kind_t kind_q;
    logic [7:0]                line_idx_q;
    logic                      first_q;

    wire [7:0] line_inc = (line_idx_q == 8'hff) ? line_idx_q :
                          line_idx_q + 8'h01;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            kind_q     <= fscf_pkg::LK_IDLE;
            line_idx_q <= 8'h00;
            first_q    <= 1'b0;
        end else if (I_FRAME_START) begin
            kind_q     <= fscf_pkg::LK_IDLE;
            line_idx_q <= 8'h00;
            first_q    <= 1'b0;
        end else if (I_LINE_START) begin
            kind_q     <= (line_idx_q < black_now) ? fscf_pkg::LK_BLACK :
                          fscf_pkg::LK_IMAGE;
            first_q    <= (line_idx_q == 8'h00);
            line_idx_q <= line_inc;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            O_BLACK_LINE <= 1'b0;
        end else begin
            O_BLACK_LINE <= (kind_q == fscf_pkg::LK_BLACK);
        end
    end

    // ---- kernel column and per-column black offsets
    logic [CW-1:0]    col_q;
    logic [PIX_W-1:0] offs_q [KERNEL];

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N || I_LINE_START) begin
            col_q <= '0;
        end else if (I_PIX_VALID) begin
            col_q <= col_q + 1'b1;
        end
    end

    // first black line may be unsettled, so it can be kept out
    wire cal_take = I_PIX_VALID && (kind_q == fscf_pkg::LK_BLACK) &&
                    !(first_q && gate_first_q);

    // simple one-sample estimate per column; no low-pass filtering here
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            for (int k = 0; k < KERNEL; k++) begin
                offs_q[k] <= '0;
            end
        end else if (cal_take) begin
            offs_q[col_q] <= I_PIX_DATA;
        end
    end

    // ---- corrected pixel; black pixels leave raw for statistics
    wire [SW-1:0] corr = {2'b00, I_PIX_DATA} + {2'b00, target_q} -
                         {2'b00, offs_q[col_q]};
    wire          is_img = (kind_q == fscf_pkg::LK_IMAGE);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            O_PIX_VALID <= 1'b0;
            O_PIX_DATA  <= '0;
        end else begin
            O_PIX_VALID <= I_PIX_VALID && !O_TRAINING;
            O_PIX_DATA  <= is_img ? clip(corr) : I_PIX_DATA;
        end
    end

    // ---- read back: shadow words, status, or geometry
    wire [15:0] status = {O_WINDOW_ENABLE_BITS, 5'h00,
                          kind_q == fscf_pkg::LK_BLACK, O_TRAINING,
                          rolling};
    logic [15:0] rsel;

    always_comb begin
        rsel = 16'h0000;
        case (I_ADDR)
            `FSCF_A_MODE:   rsel = mode_q;
            `FSCF_A_XLEN:   rsel = xlen_q;
            `FSCF_A_WIN_EN: rsel = {8'h00, win_en_q};
            `FSCF_A_BLACK:  rsel = {7'h00, black_q};
            `FSCF_A_DUMMY:  rsel = dummy_q;
            `FSCF_A_MULT:   rsel = mult_q;
            `FSCF_A_FRAME:  rsel = frame_q;
            `FSCF_A_EXPO:   rsel = expo_q;
            `FSCF_A_GAIN:   rsel = gain_q;
            `FSCF_A_SYNC:   rsel = sync_q;
            `FSCF_A_TARGET: rsel = {{(16-PIX_W){1'b0}}, target_q};
            `FSCF_A_STATUS: rsel = status;
            default:        rsel = 16'h0000;
        endcase
    end

    logic        geom_sel_q;
    logic [15:0] rd_q;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            geom_sel_q <= 1'b0;
            rd_q       <= 16'h0000;
        end else begin
            geom_sel_q <= I_RD && win_range;
            rd_q       <= I_RD ? rsel : 16'h0000;
        end
    end

    // geometry data already leave a register inside the memory
    assign O_RDATA = geom_sel_q ? geom_rdata : rd_q;
endmodule // fscf_top

//--- fscf_top_properties.sv
`timescale 1ns/100ps
`include "fscf_consts.svh"
module fscf_props #(
    parameter int NWIN = 8
) (
    input wire logic            I_SYS_CLK,
    input wire logic            I_RESET_N,
    input wire logic [8:0]      I_ADDR,
    input wire logic [15:0]     I_WDATA,
    input wire logic            I_WR,
    input wire logic            I_FRAME_START,
    input wire logic [7:0]      O_BLACK_LINES,
    input wire logic [15:0]     O_MULT_TIMER,
    input wire logic [15:0]     O_FRAME_PERIOD,
    input wire logic [15:0]     O_EXPOSURE,
    input wire logic [4:0]      O_MUX_GAINSW,
    input wire logic [7:0]      O_AFE_GAIN,
    input wire logic [NWIN-1:0] O_WINDOW_ENABLE_BITS,
    input wire logic            O_SUBSAMPLING,
    input wire logic            O_BINNING,
    input wire logic            O_TRAINING,
    input wire logic            O_PIX_VALID
);
    logic [15:0] sync_q;
    logic [15:0] shex_q;
    logic [3:0]  frz_q;
    // frz_q: {expo, gain, window, black} frozen at last frame start
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESET_N) begin
            sync_q <= `FSCF_R_SYNC;
            shex_q <= `FSCF_R_WORD;
            frz_q <= 4'h0;
        end else begin
            if (I_WR && I_ADDR == `FSCF_A_SYNC) sync_q <= I_WDATA;
            if (I_WR && I_ADDR == `FSCF_A_EXPO) shex_q <= I_WDATA;
            frz_q <= {4{I_FRAME_START}} &
                     ~{sync_q[3], sync_q[4], sync_q[5], sync_q[1]};
        end
    end
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);
    property p_no_fs;
        !$past(I_FRAME_START) |-> $stable({O_EXPOSURE, O_FRAME_PERIOD,
            O_MULT_TIMER, O_BLACK_LINES, O_AFE_GAIN});
    endproperty
    a_no_fs: assert property (p_no_fs) else $error("moved off frame");
    property p_ex_frz;
        frz_q[3] |-> $stable({O_MULT_TIMER, O_FRAME_PERIOD, O_EXPOSURE});
    endproperty
    a_ex_frz: assert property (p_ex_frz) else $error("expo not held");
    property p_gn_frz;
        frz_q[2] |-> $stable({O_MUX_GAINSW, O_AFE_GAIN});
    endproperty
    a_gn_frz: assert property (p_gn_frz) else $error("gain not held");
    property p_wn_frz;
        frz_q[1] |-> $stable({O_WINDOW_ENABLE_BITS, O_SUBSAMPLING, O_BINNING});
    endproperty
    a_wn_frz: assert property (p_wn_frz) else $error("win not held");
    property p_bl_frz;
        frz_q[0] |-> $stable(O_BLACK_LINES);
    endproperty
    a_bl_frz: assert property (p_bl_frz) else $error("black moved");
    property p_ex_load;
        I_FRAME_START && sync_q[3] |=> O_EXPOSURE == $past(shex_q);
    endproperty
    a_ex_load: assert property (p_ex_load) else $error("expo no load");
    property p_tr_rise;
        $rose(O_TRAINING) |-> $past(I_FRAME_START);
    endproperty
    a_tr_rise: assert property (p_tr_rise) else $error("train mid");
    property p_tr_mute;
        O_TRAINING && $past(O_TRAINING) |-> !O_PIX_VALID;
    endproperty
    a_tr_mute: assert property (p_tr_mute) else $error("pix in train");
endmodule // fscf_props
bind fscf_top fscf_props #(.NWIN(NWIN)) u_fscf_props (
    .I_SYS_CLK            (I_SYS_CLK),
    .I_RESET_N            (I_RESET_N),
    .I_ADDR               (I_ADDR),
    .I_WDATA              (I_WDATA),
    .I_WR                 (I_WR),
    .I_FRAME_START        (I_FRAME_START),
    .O_BLACK_LINES        (O_BLACK_LINES),
    .O_MULT_TIMER         (O_MULT_TIMER),
    .O_FRAME_PERIOD       (O_FRAME_PERIOD),
    .O_EXPOSURE           (O_EXPOSURE),
    .O_MUX_GAINSW         (O_MUX_GAINSW),
    .O_AFE_GAIN           (O_AFE_GAIN),
    .O_WINDOW_ENABLE_BITS (O_WINDOW_ENABLE_BITS),
    .O_SUBSAMPLING        (O_SUBSAMPLING),
    .O_BINNING            (O_BINNING),
    .O_TRAINING           (O_TRAINING),
    .O_PIX_VALID          (O_PIX_VALID)
);

//--- fscf_win_mem.sv
`timescale 1ns/100ps
module fscf_win_mem #(
    parameter int DEPTH = 24,
    parameter int AW    = 5
) (
    input  wire logic                I_SYS_CLK,
    input  wire logic                i_we,
    input  wire logic [AW-1:0]       i_addr,
    input  wire fscf_pkg::fscf_word_t i_wdata,
    output fscf_pkg::fscf_word_t     o_rdata
);
    fscf_pkg::fscf_word_t mem_q [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("fscf_win_mem: DEPTH does not fit AW");
    end

    // no reset on the array: geometry is software-defined before use
    always_ff @(posedge I_SYS_CLK) begin
        if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
        o_rdata <= mem_q[i_addr];
    end
endmodule // fscf_win_mem
